// >>> coprocessor_pipeline_follower_handshake_tb.sv
// Purpose: Self-checking bench, core end facing coprocessor end
// Assumes: One instruction in flight, except in the FIFO test
// Notes:   Results are noted in a queue and matched in order
`timescale 1ns/1ps
`default_nettype none
module coprocessor_pipeline_follower_handshake_tb;
  logic        clk, nrst, stall, in_valid, irq, data_abort;
  logic        present, accept, quiet, ipend;
  logic [34:0] in_data;
  logic [3:0]  wait_cnt, words, dcnt;
  logic [31:0] seed = 32'h432a, r, ie;
  logic [5:0]  re;
  logic [11:0] tbl [6] = '{12'h80b, 12'h98b, 12'h8a7, 12'h00b, 12'h809,
                          12'h808};
  wire         in_ready, dreq_n, undef_trap, cp_commit;
  int          fails, num_checks, cyc, n;
  logic [5:0]  expq [$];
  logic [31:0] iq [$];
  cph_if lnk ();
  cph_core_end #(.DEPTH(32)) u_cph_core_end (.clk(clk), .nrst(nrst),
    .lnk(lnk), .stall(stall), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .irq(irq), .data_abort(data_abort),
    .data_mem_request_n(dreq_n), .undef_trap(undef_trap),
    .cp_commit(cp_commit));
  cph_copro_end u_cph_copro_end (.clk(clk), .nrst(nrst), .lnk(lnk),
    .present(present), .accept(accept), .wait_cnt(wait_cnt),
    .words(words), .dec_instr(), .exe_instr(), .exe_valid(), .commit());
  cph_link_monitor u_cph_link_monitor (.clk(clk), .nrst(nrst),
    .coproc_fetch_strobe_n(lnk.coproc_fetch_strobe_n),
    .condition_passed(lnk.condition_passed),
    .late_cancel(lnk.late_cancel),
    .decode_handshake(lnk.decode_handshake),
    .execute_handshake(lnk.execute_handshake));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic check(string what, logic [35:0] e, logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Offer one word, f is {mem, cond_ok, is_coproc}; note its outcome
  task automatic issue(logic [2:0] f, logic [31:0] ins);
    in_data = {f, ins};
    in_valid = 1'b1;
    while (in_ready !== 1'b1) step();
    step();
    in_valid = 1'b0;
    iq.push_back(ins);
    if (!quiet && f[0] && f[1])
      expq.push_back(accept && present ? {2'b10, f[2] ? words : 4'h0}
                                       : 6'h10);
  endtask : issue
  task automatic drain(string name);
    for (int i = 0; i < 1000 && expq.size() > 0; i++) step();
    repeat (12) step();
    check("pending", 36'h0, 36'(expq.size()));
    $display("test %s done", name);
  endtask : drain
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard; the whole run needs far fewer cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  // Watch the link and the result pulses; data requests are counted
  always @(posedge clk) begin
    if (!nrst) begin
      dcnt  <= 4'h0;
      ipend <= 1'b0;
    end else begin
      // Fetched word shows on the enabled edge after the strobe
      if (ipend && lnk.coproc_clock_enable === 1'b1) begin
        ie = iq.size() ? iq.pop_front() : 'x;
        check("instr", ie, lnk.coproc_instruction_bus);
      end
      if (lnk.coproc_clock_enable === 1'b1)
        ipend <= lnk.coproc_fetch_strobe_n === 1'b0;
      if (cp_commit === 1'b1 || undef_trap === 1'b1) begin
        re = expq.size() ? expq.pop_front() : 'x;
        check("result", re, {cp_commit, undef_trap, dcnt + 4'(!dreq_n)});
        dcnt <= 4'h0;
      end else if (dreq_n === 1'b0) dcnt <= dcnt + 4'h1;
    end
  end
  initial begin
    {nrst, stall, in_valid, irq, data_abort, quiet, accept} = '0;
    {present, wait_cnt, words, in_data} = {1'b1, 4'h0, 4'h1, 35'h0};
    repeat (10) step();
    nrst = 1'b1;
    check("hs_reset", 36'h2, 36'(lnk.decode_handshake));
    // Direct, waited, multi-word, refused, failed and plain words
    for (int i = 0; i < 6; i++) begin
      {accept, wait_cnt, words} = tbl[i][11:3];
      issue(tbl[i][2:0], rnd());
      drain("table");
    end
    present = 1'b0;
    issue(3'b011, rnd());
    step();
    check("hs_none", 36'h2, 36'(lnk.execute_handshake));
    drain("absent");
    present = 1'b1;
    quiet = 1'b1;
    {wait_cnt, words} = 8'ha1;
    issue(3'b011, rnd());
    for (int i = 0; i < 20 && lnk.condition_passed !== 1'b1; i++) step();
    repeat (3) step();
    irq = 1'b1;
    for (int i = 0; i < 6 && lnk.condition_passed !== 1'b0; i++) step();
    check("pass_irq", 36'h0, 36'(lnk.condition_passed));
    irq = 1'b0;
    drain("irq");
    data_abort = 1'b1;
    wait_cnt = 4'h3;
    issue(3'b011, rnd());
    for (int i = 0; i < 10 && lnk.late_cancel !== 1'b1; i++) step();
    check("late", 36'h1, 36'(lnk.late_cancel));
    data_abort = 1'b0;
    drain("late");
    quiet = 1'b0;
    // Fill while the core stalls, then drain against a slow far end
    stall = 1'b1;
    {wait_cnt, words} = 8'h32;
    n = 0;
    while (in_ready === 1'b1 && n < 40) begin
      issue(3'b111, rnd());
      step();
      n++;
    end
    check("fill", 36'd32, 36'(n));
    stall = 1'b0;
    drain("fifo");
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      accept = r[0];
      wait_cnt = {2'b00, r[2:1]};
      words = {2'b00, r[4:3]} + 4'h1;
      issue(r[7:5], rnd());
      drain("random");
    end
    results();
  end
endmodule : coprocessor_pipeline_follower_handshake_tb
`default_nettype wire

// >>> cph_copro_end.sv
// Purpose: Coprocessor pipeline follower end
// Assumes: User supplies accept, wait count and word count per instr
// Notes:   Commits only on pass with GO or LAST
`timescale 1ns/1ps
`default_nettype none
`include "cph_map.svh"
module cph_copro_end #(
  parameter int IW = `CPH_INSTR_W
) (
  input  wire logic          clk,        // Clock
  input  wire logic          nrst,       // Sync reset, low
  cph_if.copro               lnk,        // Core link
  input  wire logic          present,    // Coprocessor fitted
  input  wire logic          accept,     // Decode instr is ours
  input  wire logic [3:0]    wait_cnt,   // Busy-wait cycles wanted
  input  wire logic [3:0]    words,      // Transfer words, 1 or more
  output logic [IW-1:0]      dec_instr,  // Decode stage instruction
  output logic [IW-1:0]      exe_instr,  // Execute stage instruction
  output logic               exe_valid,  // Execute stage occupied
  output logic               commit      // State change pulse
);
  typedef struct packed {
    logic [IW-1:0] d;
    logic [IW-1:0] x;
    logic          x_v;
    logic          pend;
    logic          cap;
    logic [3:0]    wt;
    logic [3:0]    rem;
    logic [1:0]    hs;
    logic          cm;
  } cph_cp_t;

  cph_cp_t c_q;
  cph_cp_t c_d;
  logic    adv;

  // Respond code from remaining work
  function automatic logic [1:0] resp(input logic [3:0] w,
                                      input logic [3:0] r);
    if (w != 4'h0) begin
      return `CPH_HS_WAIT;
    end else if (r > 4'h1) begin
      return `CPH_HS_GO;
    end
    return `CPH_HS_LAST;
  endfunction : resp

  // Enable qualifies every edge instead of a gated clock
  assign adv = lnk.coproc_clock_enable;

  // Follower and response logic
  always_comb begin
    c_d    = c_q;
    c_d.cm = 1'b0;
    if (c_q.x_v && adv) begin
      if (lnk.late_cancel) begin
        c_d.x_v = 1'b0;
      end else if (lnk.condition_passed && c_q.hs != `CPH_HS_WAIT
                   && c_q.hs != `CPH_HS_ABSENT) begin
        c_d.cm = 1'b1;
        if (c_q.hs == `CPH_HS_LAST) begin
          c_d.x_v = 1'b0;
        end else begin
          c_d.rem = c_q.rem - 4'h1;
        end
      end else if (c_q.hs == `CPH_HS_WAIT) begin
        if (!lnk.condition_passed && c_q.cap) begin
          c_d.x_v = 1'b0;
        end else if (c_q.wt != 4'h0) begin
          c_d.wt = c_q.wt - 4'h1;
        end
      end
      c_d.cap = 1'b1;
    end
    // Bus word after the strobe edge is the fetched one; one word is in
    // flight, so it fills decode and execute together
    if (c_q.pend && adv) begin
      c_d.d    = lnk.coproc_instruction_bus;
      c_d.x    = lnk.coproc_instruction_bus;
      c_d.x_v  = accept;
      c_d.cap  = 1'b0;
      c_d.pend = 1'b0;
      c_d.wt   = wait_cnt;
      c_d.rem  = (words == 4'h0) ? 4'h1 : words;
    end
    if (adv && !lnk.coproc_fetch_strobe_n) begin
      c_d.pend = 1'b1;
    end
    if (!c_d.x_v) begin
      c_d.cap = 1'b0;
    end
    // Absent when unfitted or nothing to run
    if (!present || !c_d.x_v) begin
      c_d.hs = `CPH_HS_ABSENT;
    end else begin
      c_d.hs = resp(c_d.wt, c_d.rem);
    end
  end

  // Stages empty from reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      c_q    <= '0;
      c_q.hs <= `CPH_HS_ABSENT;
    end else begin
      c_q <= c_d;
    end
  end

  assign lnk.decode_handshake  = c_q.hs;
  assign lnk.execute_handshake = c_q.hs;
  assign dec_instr = c_q.d;
  assign exe_instr = c_q.x;
  assign exe_valid = c_q.x_v;
  assign commit    = c_q.cm;
endmodule : cph_copro_end
`default_nettype wire

// >>> cph_core_end.sv
// Purpose: Core end of the pipelined coprocessor handshake
// Assumes: Instructions arrive from a FIFO; user flags which are coproc
// Notes:   Registered link and result outputs; trap and commit pulses report results
//          One instruction is in flight at a time: the far end fills its
//          decode and execute stages from a single bus word, so a second
//          fetch before the first retires would overwrite it
//          The popped word reaches the bus one enabled edge after the
//          strobe, which adds a cycle of latency per instruction
`timescale 1ns/1ps
`default_nettype none
`include "cph_map.svh"
module cph_core_end #(
  parameter int IW    = `CPH_INSTR_W,
  parameter int DEPTH = `CPH_FIFO_DEPTH
) (
  input  wire logic          clk,          // Clock
  input  wire logic          nrst,         // Sync reset, low
  cph_if.core                lnk,          // Coprocessor link
  input  wire logic          stall,        // Core pipeline stall
  input  wire logic          in_valid,     // Instruction offered
  output logic               in_ready,     // FIFO has room
  input  wire logic [IW+2:0] in_data,      // {mem,cond_ok,is_cp,instr}
  input  wire logic          irq,          // Interrupt request
  input  wire logic          data_abort,   // Preceding data abort
  output logic               data_mem_request_n, // Data access, low
  output logic               undef_trap,   // Undefined trap pulse
  output logic               cp_commit     // Commit pulse
);
  typedef struct packed {
    cph_pkg::cph_state_t st;
    logic          en;
    logic          strobe_n;
    logic [IW-1:0] instr;
    logic [IW-1:0] fw;     // Popped word, not yet on the bus
    logic          f_v;    // Fetch stage occupied
    logic          f_cp;   // Fetch stage is a coproc instruction
    logic          f_ok;   // Fetch stage passed its condition
    logic          f_mem;  // Fetch stage is a memory transfer
    logic          d_cp;
    logic          d_ok;
    logic          d_mem;
    logic          d_v;
    logic          x_mem;
    logic          pass;
    logic          late;
    logic          dreq_n;
    logic          trap;
    logic          commit;
  } cph_core_t;

  cph_core_t s_q;
  cph_core_t s_d;
  logic            f_valid;
  logic [IW+2:0]   f_data;
  logic            f_pop;
  logic            imreq_n;
  logic            busy;
  logic [1:0]      hs_in;

  // FIFO ahead of fetch absorbs bursts; core stalls block fetch and let it fill
  cph_fifo #(.WIDTH(IW + 3), .DEPTH(DEPTH)) u_fifo (
    .clk     (clk),
    .nrst    (nrst),
    .s_valid (in_valid),
    .s_ready (in_ready),
    .s_data  (in_data),
    .m_valid (f_valid),
    .m_ready (f_pop),
    .m_data  (f_data)
  );

  // Pipeline moves only when not stalled and not in execute wait
  function automatic logic hs_ok(input logic [1:0] h);
    return (h == `CPH_HS_GO) || (h == `CPH_HS_LAST);
  endfunction : hs_ok

  // Any word still in fetch, decode or execute blocks the next fetch
  assign busy    = s_q.f_v || s_q.d_v || (s_q.st != cph_pkg::CPH_IDLE);
  assign imreq_n = !(f_valid && !stall && !busy);
  assign f_pop   = !imreq_n;

  // First execute cycle answers on decode bus, later ones on execute
  assign hs_in = (s_q.st == cph_pkg::CPH_EXEC) ?
                 lnk.decode_handshake : lnk.execute_handshake;

  // Next-state logic
  always_comb begin
    s_d        = s_q;
    s_d.trap   = 1'b0;
    s_d.commit = 1'b0;
    s_d.late   = 1'b0;
    s_d.en     = !stall;
    s_d.strobe_n = imreq_n;
    s_d.dreq_n = 1'b1;
    // Popped word waits one cycle; the strobe goes out first
    if (!imreq_n) begin
      s_d.fw    = f_data[IW-1:0];
      s_d.f_v   = 1'b1;
      s_d.f_cp  = f_data[IW];
      s_d.f_ok  = f_data[IW+1];
      s_d.f_mem = f_data[IW+2];
    end
    // Strobe edge seen by the far end: the word follows on the bus
    if (s_q.f_v && s_q.en) begin
      s_d.instr = s_q.fw;
      s_d.f_v   = 1'b0;
      s_d.d_v   = 1'b1;
      s_d.d_cp  = s_q.f_cp;
      s_d.d_ok  = s_q.f_ok;
      s_d.d_mem = s_q.f_mem;
    end
    case (s_q.st)
      cph_pkg::CPH_IDLE: begin
        s_d.pass = 1'b0;
        // Decode moves to execute only on an enabled edge
        if (s_q.d_v && s_q.en) begin
          s_d.d_v = 1'b0;
          if (s_q.d_cp && s_q.d_ok) begin
            s_d.x_mem = s_q.d_mem;
            s_d.pass  = 1'b1;
            s_d.st    = cph_pkg::CPH_EXEC;
          end
        end
      end
      cph_pkg::CPH_EXEC,
      cph_pkg::CPH_BUSY: begin
        s_d.late = (s_q.st == cph_pkg::CPH_EXEC) && s_q.en
                   && data_abort;
        if (!s_q.en) begin
          // Stalled: the far end holds too, so nothing is sampled
          s_d.st = s_q.st;
        end else if (s_d.late || irq) begin
          s_d.pass = 1'b0;
          s_d.st   = cph_pkg::CPH_IDLE;
        end else if (hs_in == `CPH_HS_ABSENT) begin
          s_d.trap = 1'b1;
          s_d.pass = 1'b0;
          s_d.st   = cph_pkg::CPH_IDLE;
        end else if (hs_in == `CPH_HS_WAIT) begin
          s_d.st = cph_pkg::CPH_BUSY;
        end else if (hs_ok(hs_in)) begin
          // One data request per GO or LAST answer to a memory transfer
          s_d.dreq_n = !s_q.x_mem;
          if (hs_in == `CPH_HS_LAST) begin
            s_d.commit = 1'b1;
            s_d.pass   = 1'b0;
            s_d.st     = cph_pkg::CPH_IDLE;
          end else begin
            s_d.st = cph_pkg::CPH_BUSY;
          end
        end
      end
      default: begin
        s_d.st = cph_pkg::CPH_IDLE;
      end
    endcase
  end

  // State register; reset empties every stage so no stale word
  // can be taken for a fetch after reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.st       <= cph_pkg::CPH_IDLE;
      s_q.strobe_n <= 1'b1;
      s_q.dreq_n   <= 1'b1;
      s_q.instr    <= `CPH_NOP_INSTR;
    end else begin
      s_q <= s_d;
    end
  end

  // Link and result outputs all come straight from the state register
  assign lnk.coproc_clock_enable    = s_q.en;
  assign lnk.coproc_fetch_strobe_n  = s_q.strobe_n;
  assign lnk.coproc_instruction_bus = s_q.instr;
  assign lnk.condition_passed       = s_q.pass;
  assign lnk.late_cancel            = s_q.late;
  assign data_mem_request_n         = s_q.dreq_n;
  assign undef_trap                 = s_q.trap;
  assign cp_commit                  = s_q.commit;
endmodule : cph_core_end
`default_nettype wire

// >>> cph_fifo.sv
// Purpose: Instruction FIFO feeding the core end
// Assumes: Synchronous reset, single clock
// Notes:   Width and depth are parameters; depth a power of two
`timescale 1ns/1ps
`default_nettype none
module cph_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,     // Clock
  input  wire logic             nrst,    // Sync reset, low
  input  wire logic             s_valid, // Write valid
  output logic                  s_ready, // Not full
  input  wire logic [WIDTH-1:0] s_data,  // Write word
  output logic                  m_valid, // Not empty
  input  wire logic             m_ready, // Read accept
  output logic [WIDTH-1:0]      m_data   // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign s_ready = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
  assign m_valid = wp_q != rp_q;
  assign m_data  = mem_q[rp_q[AW-1:0]];
  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;

  // Storage carries no reset; pointers alone define contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= s_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule : cph_fifo
`default_nettype wire

// >>> cph_if.sv
// Purpose: Link between core end and coprocessor end
// Assumes: One clock, signals sampled on clk rising edge
// Notes:   No clocking block
`timescale 1ns/1ps
`default_nettype none
`include "cph_map.svh"
interface cph_if;
  logic                    coproc_clock_enable;
  logic                    coproc_fetch_strobe_n;
  logic [`CPH_INSTR_W-1:0] coproc_instruction_bus;
  logic                    condition_passed;
  logic                    late_cancel;
  logic [1:0]              decode_handshake;
  logic [1:0]              execute_handshake;
  modport core (
    output coproc_clock_enable, coproc_fetch_strobe_n,
           coproc_instruction_bus, condition_passed, late_cancel,
    input  decode_handshake, execute_handshake
  );
  modport copro (
    input  coproc_clock_enable, coproc_fetch_strobe_n,
           coproc_instruction_bus, condition_passed, late_cancel,
    output decode_handshake, execute_handshake
  );
endinterface : cph_if
`default_nettype wire

// >>> cph_link_monitor.sv
// Purpose: Assertions on the core to coprocessor link
// Assumes: One clock; sees the link signals only
// Notes:   Pass bound covers 15 waits and 15 words
`timescale 1ns/1ps
`default_nettype none
module cph_link_monitor (
  input wire logic       clk,                   // Clock
  input wire logic       nrst,                  // Sync reset, low
  input wire logic       coproc_fetch_strobe_n, // Fetch strobe
  input wire logic       condition_passed,      // Pass flag
  input wire logic       late_cancel,           // Cancel flag
  input wire logic [1:0] decode_handshake,      // Decode answer
  input wire logic [1:0] execute_handshake      // Execute answer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Pass seen with a final or a refusing answer
  sequence s_last;
    condition_passed && execute_handshake == 2'b11;
  endsequence
  sequence s_absent;
    condition_passed && execute_handshake == 2'b10;
  endsequence
  // Both buses come from one register, so they never differ
  property p_one_code; decode_handshake == execute_handshake; endproperty
  property p_last_ends; s_last |=> !condition_passed; endproperty
  property p_absent_ends; s_absent |=> !condition_passed; endproperty
  property p_late_pulse; late_cancel |=> !late_cancel; endproperty
  property p_late_after; late_cancel |-> $past(condition_passed); endproperty
  property p_late_drops; late_cancel |=> !condition_passed; endproperty
  property p_pass_fetch;
    $rose(condition_passed) |-> !$past(coproc_fetch_strobe_n, 2);
  endproperty
  // A stuck pass would hang the core, so bound the whole instruction
  property p_pass_bound;
    $rose(condition_passed) |-> ##[1:40] !condition_passed;
  endproperty
  a_one_code: assert property (p_one_code)
    else $error("handshake buses differ");
  a_last_ends: assert property (p_last_ends)
    else $error("pass held after final answer");
  a_absent_ends: assert property (p_absent_ends)
    else $error("pass held after absent answer");
  a_late_pulse: assert property (p_late_pulse)
    else $error("late cancel longer than one cycle");
  a_late_after: assert property (p_late_after)
    else $error("late cancel without execute cycle");
  a_late_drops: assert property (p_late_drops)
    else $error("pass held after late cancel");
  a_pass_fetch: assert property (p_pass_fetch)
    else $error("pass without preceding fetch");
  a_pass_bound: assert property (p_pass_bound)
    else $error("pass never released");
endmodule : cph_link_monitor
`default_nettype wire

// >>> cph_map.svh
// Purpose: Constants for the coprocessor pipeline follower handshake
// Assumes: Single clock, core and coprocessor share clk
// Notes:   Handshake codes and reset values
`ifndef CPH_MAP_SVH
`define CPH_MAP_SVH
`define CPH_HS_ABSENT   2'b10
`define CPH_HS_WAIT     2'b00
`define CPH_HS_GO       2'b01
`define CPH_HS_LAST     2'b11
`define CPH_INSTR_W     32
`define CPH_NOP_INSTR   32'h0000_0000
`define CPH_FIFO_DEPTH  32
`endif

// >>> cph_pkg.sv
// Purpose: Types for the coprocessor pipeline follower handshake
// Assumes: cph_map.svh gives the encodings
// Notes:   Types only
`include "cph_map.svh"
package cph_pkg;
  typedef logic [1:0] cph_hs_t;
  // Core-side sequencer states, Gray coded in IDLE-EXEC-BUSY-LATE order
  typedef enum logic [1:0] {
    CPH_IDLE = 2'b00,
    CPH_EXEC = 2'b01,
    CPH_BUSY = 2'b11,
    CPH_LATE = 2'b10
  } cph_state_t;
endpackage : cph_pkg
